// File: gdfn_cfg.svh
// timing counts and register offsets for the gate drive fault and non-overlap block
`ifndef GDFN_CFG_SVH
`define GDFN_CFG_SVH
// clock period in picoseconds (40 MHz)
`define GDFN_CLK_PS 25000
// non-overlap delay step in picoseconds per configured unit
`define GDFN_NOV_STEP_PS 5500
// fault latch time in milliseconds
`define GDFN_LATCH_MS 14
// latch cycles: 14 ms at 40 MHz
`define GDFN_LATCH_CYC ((`GDFN_LATCH_MS * 1000000) / (`GDFN_CLK_PS / 1000))
// default blanking time in nanoseconds
`define GDFN_BLANK_NS 1050
// blanking cycles, rounded up
`define GDFN_BLANK_CYC ((`GDFN_BLANK_NS * 1000 + `GDFN_CLK_PS - 1) / `GDFN_CLK_PS)
// default non-overlap setting in units
`define GDFN_NOV_UNITS 68
// default propagation delay in cycles
`define GDFN_PROP_CYC 2
// register offsets
`define GDFN_REG_NOV 4'h0
`define GDFN_REG_STATUS 4'h1
`define GDFN_REG_CLEAR 4'h2
`define GDFN_REG_ENABLE 4'h3
`define GDFN_REG_LIVE 4'h4
// status bit positions
`define GDFN_EV_DESAT_LO 0
`define GDFN_EV_DESAT_HI 1
`define GDFN_EV_UV_LO 2
`define GDFN_EV_UV_HI 3
`define GDFN_EV_PRIM 4
`define GDFN_EV_W 5
`endif

// File: gdfn_pkg.sv
// types shared by the gate drive fault and non-overlap block
`include "gdfn_cfg.svh"
package gdfn_pkg;
    // per-side gate channel state
    typedef enum logic [1:0] {CH_RUN, CH_SOFT, CH_LATCH, CH_WAIT} gdfn_ch_t;
    // side comparator inputs
    typedef struct packed {
        logic desat;
        logic undervolt;
    } gdfn_sense_t;
    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } gdfn_bus_t;
endpackage

// File: gdfn_top.sv
// gate drive fault and non-overlap logic for one phase
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "gdfn_cfg.svh"
module gdfn_top #(
    parameter int LATCH_CYC = `GDFN_LATCH_CYC,
    parameter int BLANK_CYC = `GDFN_BLANK_CYC,
    parameter int PROP_CYC = `GDFN_PROP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic bridge_hold_off_n,
    input wire logic top_switch_command,
    input wire logic bottom_switch_command,
    input wire logic mode_select_strap,
    input wire gdfn_pkg::gdfn_sense_t low_sense,
    input wire gdfn_pkg::gdfn_sense_t high_sense,
    input wire logic primary_fault,
    input wire gdfn_pkg::gdfn_bus_t bus,
    output logic [15:0] rdata,
    output logic irq,
    output logic low_gate_drive,
    output logic high_gate_drive,
    output logic low_soft_off,
    output logic high_soft_off,
    output logic side_fault_out_n_oe,
    output logic side_fault_out_n_o
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [6:0] sync1_r, sync1_nxt; // first stage
    logic [6:0] sync2_r, sync2_nxt; // second stage
    always_comb begin
        sync1_nxt = {bridge_hold_off_n, top_switch_command, bottom_switch_command,
                     low_sense.desat, low_sense.undervolt,
                     high_sense.desat, high_sense.undervolt};
        sync2_nxt = sync1_r;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 7'h00;
            sync2_r <= 7'h00;
        end else if (clk_en) begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end
    logic hold_n_s, top_s, bot_s; // synchronised commands
    logic [1:0] desat_s, uv_s; // index 0 low side, 1 high side
    assign hold_n_s = sync2_r[6];
    assign top_s = sync2_r[5];
    assign bot_s = sync2_r[4];
    assign desat_s = {sync2_r[1], sync2_r[3]};
    assign uv_s = {sync2_r[0], sync2_r[2]};

    // ----------------------------------------------------------------
    // strap capture and register file
    // ----------------------------------------------------------------
    logic strap_r, strap_nxt; // local mode when high
    logic strap_done_r, strap_done_nxt; // strap caught after reset
    logic [15:0] nov_r, nov_nxt; // non-overlap units
    logic [`GDFN_EV_W-1:0] stat_r, stat_nxt; // sticky events
    logic [`GDFN_EV_W-1:0] ena_r, ena_nxt; // interrupt enables
    logic [15:0] rdata_nxt; // read data next
    logic irq_nxt; // interrupt next
    logic [`GDFN_EV_W-1:0] ev; // event pulses
    logic [`GDFN_EV_W-1:0] live; // live fault levels
    always_comb begin
        strap_nxt = strap_done_r ? strap_r : mode_select_strap;
        strap_done_nxt = 1'b1;
        nov_nxt = nov_r;
        ena_nxt = ena_r;
        stat_nxt = stat_r;
        if (bus.wr && bus.addr == `GDFN_REG_NOV) begin
            nov_nxt = bus.wdata;
        end
        if (bus.wr && bus.addr == `GDFN_REG_ENABLE) begin
            ena_nxt = bus.wdata[`GDFN_EV_W-1:0];
        end
        if (bus.wr && bus.addr == `GDFN_REG_CLEAR) begin
            stat_nxt = stat_nxt & ~bus.wdata[`GDFN_EV_W-1:0];
        end
        stat_nxt = stat_nxt | ev; // set wins over clear
        rdata_nxt = 16'h0000;
        if (bus.rd) begin
            unique case (bus.addr)
                `GDFN_REG_NOV: rdata_nxt = nov_r;
                `GDFN_REG_STATUS: rdata_nxt = {11'h000, stat_r};
                `GDFN_REG_ENABLE: rdata_nxt = {11'h000, ena_r};
                `GDFN_REG_LIVE: rdata_nxt = {10'h000, strap_r, live};
                default: rdata_nxt = 16'h0000;
            endcase
        end
        irq_nxt = |(stat_nxt & ena_nxt);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_r <= 1'b0;
            strap_done_r <= 1'b0;
            nov_r <= 16'(`GDFN_NOV_UNITS);
            stat_r <= '0;
            ena_r <= '0;
            rdata <= 16'h0000;
            irq <= 1'b0;
        end else if (clk_en) begin
            strap_r <= strap_nxt;
            strap_done_r <= strap_done_nxt;
            nov_r <= nov_nxt;
            stat_r <= stat_nxt;
            ena_r <= ena_nxt;
            rdata <= rdata_nxt;
            irq <= irq_nxt;
        end
    end

    // ----------------------------------------------------------------
    // command shaping and non-overlap
    // ----------------------------------------------------------------
    logic top_eff, bot_eff; // commands after hold-off
    logic [1:0] want; // requested gate per side
    logic [1:0] want_r, want_nxt; // previous request
    logic [31:0] nov_cyc; // non-overlap in cycles
    logic [31:0] nov_cnt_r, nov_cnt_nxt; // dead time counter
    logic [1:0] cmd_r, cmd_nxt; // gate commands after dead time
    assign nov_cyc = (32'(nov_r) * `GDFN_NOV_STEP_PS + `GDFN_CLK_PS - 1) / `GDFN_CLK_PS;
    always_comb begin
        top_eff = top_s & hold_n_s;
        bot_eff = bot_s & hold_n_s;
        if (strap_r) begin
            // local: low gate on while top low, also under hold-off
            want = {top_eff, ~top_eff};
        end else begin
            // direct: controller owns the dead time
            want = {top_eff, bot_eff};
        end
        want_nxt = want;
        nov_cnt_nxt = nov_cnt_r;
        cmd_nxt = cmd_r;
        if (!strap_r) begin
            cmd_nxt = want;
        end else if (want != want_r) begin
            cmd_nxt = 2'b00; // both off, start dead time
            nov_cnt_nxt = nov_cyc;
        end else if (nov_cnt_r != 32'h0) begin
            nov_cnt_nxt = nov_cnt_r - 32'h1;
        end else begin
            cmd_nxt = want;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            want_r <= 2'b00;
            nov_cnt_r <= 32'h0;
            cmd_r <= 2'b00;
        end else if (clk_en) begin
            want_r <= want_nxt;
            nov_cnt_r <= nov_cnt_nxt;
            cmd_r <= cmd_nxt;
        end
    end

    // ----------------------------------------------------------------
    // propagation delay line
    // ----------------------------------------------------------------
    logic [1:0] dly_r [PROP_CYC]; // fixed delay taps
    logic [1:0] dly_nxt [PROP_CYC];
    logic [1:0] cmd_d; // delayed gate commands
    always_comb begin
        dly_nxt[0] = cmd_r;
        for (int i = 1; i < PROP_CYC; i++) begin
            dly_nxt[i] = dly_r[i-1];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PROP_CYC; i++) begin
                dly_r[i] <= 2'b00;
            end
        end else if (clk_en) begin
            dly_r <= dly_nxt;
        end
    end
    assign cmd_d = dly_r[PROP_CYC-1];

    // ----------------------------------------------------------------
    // per-side protection channels
    // ----------------------------------------------------------------
    logic [1:0] gate_q; // gate drive per side
    logic [1:0] soft_q; // soft turn-off per side
    logic [1:0] fault_q; // side fault indication
    logic prim_s; // primary fault
    assign prim_s = primary_fault;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_side
            gdfn_pkg::gdfn_ch_t st_r, st_nxt; // channel state
            logic [31:0] tmr_r, tmr_nxt; // blank or latch timer
            logic gate_r, gate_nxt; // gate drive
            logic cprev_r, cprev_nxt; // previous command
            logic cause; // fault present now
            logic desat_hit; // desat after blanking
            always_comb begin
                cause = uv_s[g] | prim_s;
                desat_hit = gate_r && tmr_r == 32'h0 && desat_s[g];
                st_nxt = st_r;
                tmr_nxt = tmr_r;
                gate_nxt = gate_r;
                cprev_nxt = cmd_d[g];
                unique case (st_r)
                    gdfn_pkg::CH_RUN: begin
                        if (cause || desat_hit) begin
                            st_nxt = gdfn_pkg::CH_SOFT;
                            gate_nxt = 1'b0;
                            tmr_nxt = 32'(LATCH_CYC);
                        end else begin
                            gate_nxt = cmd_d[g];
                            if (cmd_d[g] && !gate_r) begin
                                tmr_nxt = 32'(BLANK_CYC);
                            end else if (tmr_r != 32'h0) begin
                                tmr_nxt = tmr_r - 32'h1;
                            end
                        end
                    end
                    gdfn_pkg::CH_SOFT: begin
                        st_nxt = gdfn_pkg::CH_LATCH;
                    end
                    gdfn_pkg::CH_LATCH: begin
                        if (tmr_r > 32'h1) begin
                            tmr_nxt = tmr_r - 32'h1;
                        end else begin
                            tmr_nxt = 32'h0;
                            st_nxt = gdfn_pkg::CH_WAIT;
                        end
                    end
                    gdfn_pkg::CH_WAIT: begin
                        if (!cause && cmd_d[g] && !cprev_r) begin
                            st_nxt = gdfn_pkg::CH_RUN;
                            gate_nxt = 1'b1;
                            tmr_nxt = 32'(BLANK_CYC);
                        end
                    end
                endcase
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    st_r <= gdfn_pkg::CH_RUN;
                    tmr_r <= 32'h0;
                    gate_r <= 1'b0;
                    cprev_r <= 1'b0;
                end else if (clk_en) begin
                    st_r <= st_nxt;
                    tmr_r <= tmr_nxt;
                    gate_r <= gate_nxt;
                    cprev_r <= cprev_nxt;
                end
            end
            assign gate_q[g] = gate_r;
            assign soft_q[g] = (st_r == gdfn_pkg::CH_SOFT);
            // fault held through soft-off and latch, and while cause persists
            assign fault_q[g] = (st_r == gdfn_pkg::CH_SOFT) || (st_r == gdfn_pkg::CH_LATCH) ||
                                (st_r == gdfn_pkg::CH_WAIT && cause);
            assign ev[g] = (st_r == gdfn_pkg::CH_RUN) && desat_hit && !cause;
            assign ev[g+2] = (st_r == gdfn_pkg::CH_RUN) && uv_s[g];
        end
    endgenerate
    assign ev[`GDFN_EV_PRIM] = prim_s && !stat_r[`GDFN_EV_PRIM];
    assign live = {prim_s, uv_s[1], uv_s[0], fault_q[1], fault_q[0]};

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    logic fault_oe_nxt; // fault drive enable next
    always_comb begin
        fault_oe_nxt = fault_q[0] | fault_q[1] | prim_s;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_gate_drive <= 1'b0;
            high_gate_drive <= 1'b0;
            low_soft_off <= 1'b0;
            high_soft_off <= 1'b0;
            side_fault_out_n_oe <= 1'b0;
            side_fault_out_n_o <= 1'b0;
        end else if (clk_en) begin
            low_gate_drive <= gate_q[0];
            high_gate_drive <= gate_q[1];
            low_soft_off <= soft_q[0];
            high_soft_off <= soft_q[1];
            side_fault_out_n_oe <= fault_oe_nxt;
            side_fault_out_n_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_hold_direct;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !strap_r && !hold_n_s) |-> !want[0] && !want[1];
    endproperty
    a_hold_direct: assert property (p_hold_direct) else $error("hold-off left gate on");
    property p_hold_local;
        @(posedge clk) disable iff (!rst_n)
        (strap_r && !hold_n_s) |-> want == 2'b01;
    endproperty
    a_hold_local: assert property (p_hold_local) else $error("local hold-off wrong");
    property p_no_overlap;
        @(posedge clk) disable iff (!rst_n)
        strap_r |-> !(cmd_r[0] && cmd_r[1]);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("gate overlap");
    property p_fault_pin;
        @(posedge clk) disable iff (!rst_n)
        clk_en |=> side_fault_out_n_oe == $past(fault_oe_nxt);
    endproperty
    a_fault_pin: assert property (p_fault_pin) else $error("fault pin mismatch");
    property p_prim_off;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && prim_s) ##1 clk_en |=> !low_gate_drive && !high_gate_drive;
    endproperty
    a_prim_off: assert property (p_prim_off) else $error("primary fault gates on");
    property p_uv_fault;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && uv_s != 2'b00) ##1 clk_en |=> side_fault_out_n_oe;
    endproperty
    a_uv_fault: assert property (p_uv_fault) else $error("undervoltage not flagged");
    property p_latch_off;
        @(posedge clk) disable iff (!rst_n)
        (g_side[0].st_r == gdfn_pkg::CH_LATCH) |-> !g_side[0].gate_r && fault_q[0];
    endproperty
    a_latch_off: assert property (p_latch_off) else $error("latch gate on");
    property p_resume;
        @(posedge clk) disable iff (!rst_n)
        (g_side[0].st_r == gdfn_pkg::CH_WAIT && !g_side[0].gate_nxt && clk_en)
            |=> !g_side[0].gate_r;
    endproperty
    a_resume: assert property (p_resume) else $error("resume without edge");
endmodule
`default_nettype wire

// File: gdfn_ctrl_model.sv
// model of the external inverter controller driving the switch commands
`timescale 1ns/1ps
`default_nettype none
module gdfn_ctrl_model #(
    parameter int DEAD_CYC = 4 // controller dead time in clock cycles, less one (both commands stay low DEAD_CYC + 1 cycles)
) (
    input wire logic clk,
    output logic top_switch_command,
    output logic bottom_switch_command
);
    // ----------------------------------------
    // command driver
    // ----------------------------------------
    // both commands start off
    initial begin
        top_switch_command = 1'h0;
        bottom_switch_command = 1'h0;
    end

    // new command pair, never both high, dead time before the opposite side
    task automatic put(input logic t, input logic b);
        if (t && b) begin // both asked: top wins
            b = 1'h0;
        end
        if ((t && bottom_switch_command) || (b && top_switch_command)) begin // side swap
            @(posedge clk);
            top_switch_command <= 1'h0;
            bottom_switch_command <= 1'h0;
            repeat (DEAD_CYC) @(posedge clk);
        end
        @(posedge clk);
        top_switch_command <= t;
        bottom_switch_command <= b;
    endtask
endmodule
`default_nettype wire

// File: test_gate_drive_fault_nonoverlap.sv
// self-checking testbench of the gate drive fault and non-overlap block
`timescale 1ns/1ps
`default_nettype none
`include "gdfn_cfg.svh"
module test_gate_drive_fault_nonoverlap;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk;
    logic rst_n;
    logic bridge_hold_off_n;
    logic mode_select_strap;
    logic primary_fault;
    logic top_cmd; // from controller model
    logic bot_cmd; // from controller model
    gdfn_pkg::gdfn_sense_t low_sense;
    gdfn_pkg::gdfn_sense_t high_sense;
    gdfn_pkg::gdfn_bus_t bus;
    logic [15:0] rdata;
    logic [15:0] rv; // read value
    logic irq;
    logic low_gate_drive;
    logic high_gate_drive;
    logic low_soft_off;
    logic high_soft_off;
    logic side_fault_out_n_oe;
    logic side_fault_out_n_o;
    int err_count = 0;
    int check_count = 0;
    int n; // cycle counts
    int cnt;
    logic flag;
    // rows: hold_off_n, top, bottom, expected low gate, expected high gate
    logic [4:0] rows [6] = '{5'h00, 5'h16, 5'h19, 5'h0C, 5'h04, 5'h10};

    // ----------------------------------------
    // clock, model and design
    // ----------------------------------------
    // 40 MHz clock
    always #12.5 clk = ~clk;

    gdfn_ctrl_model ctrl (.clk(clk), .top_switch_command(top_cmd),
        .bottom_switch_command(bot_cmd));

    gdfn_top #(.LATCH_CYC(20), .BLANK_CYC(16), .PROP_CYC(2)) dut (
        .clk(clk), .rst_n(rst_n), .clk_en(1'h1), .bridge_hold_off_n(bridge_hold_off_n),
        .top_switch_command(top_cmd), .bottom_switch_command(bot_cmd),
        .mode_select_strap(mode_select_strap), .low_sense(low_sense),
        .high_sense(high_sense), .primary_fault(primary_fault), .bus(bus),
        .rdata(rdata), .irq(irq), .low_gate_drive(low_gate_drive),
        .high_gate_drive(high_gate_drive), .low_soft_off(low_soft_off),
        .high_soft_off(high_soft_off), .side_fault_out_n_oe(side_fault_out_n_oe),
        .side_fault_out_n_o(side_fault_out_n_o));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // counts, verdict, end of run
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // reset with given strap
    task automatic do_reset(input logic s);
        rst_n <= 1'h0;
        mode_select_strap <= s;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
    endtask

    // one-cycle register write
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'h0, rd: 1'h0};
    endtask

    // one-cycle register read, data taken in the following cycle
    task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h1};
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h0};
        #1 d = rdata;
    endtask

    // cycles until a gate reaches a level, bounded at 60
    task automatic wait_gate(input bit hi, input logic v, output int k);
        k = 0;
        while (((hi ? high_gate_drive : low_gate_drive) !== v) && k < 60) begin
            @(posedge clk);
            #1 k++;
        end
    endtask

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 1'h0;
        rst_n = 1'h0;
        bridge_hold_off_n = 1'h1;
        mode_select_strap = 1'h0;
        primary_fault = 1'h0;
        low_sense = '0;
        high_sense = '0;
        bus = '0;
        do_reset(1'h0);
        // outputs quiet after reset, default delay setting, unmapped read
        #1 check(16'({low_gate_drive, high_gate_drive, side_fault_out_n_oe, irq}), 16'h0000);
        check(16'(side_fault_out_n_o), 16'h0000);
        bus_rd(`GDFN_REG_NOV, rv);
        check(rv, 16'h0044);
        bus_rd(4'hF, rv);
        check(rv, 16'h0000);
        // direct mode table, hold-off rows included
        foreach (rows[i]) begin
            bridge_hold_off_n <= rows[i][4];
            ctrl.put(rows[i][3], rows[i][2]);
            repeat (12) @(posedge clk);
            #1 check(16'({low_gate_drive, high_gate_drive}), 16'(rows[i][1:0]));
            check(16'(side_fault_out_n_oe), 16'h0000);
        end
        bridge_hold_off_n <= 1'h1;
        // rise and fall delays equal
        ctrl.put(1'h0, 1'h1);
        wait_gate(1'h0, 1'h1, n);
        ctrl.put(1'h0, 1'h0);
        wait_gate(1'h0, 1'h0, cnt);
        check(16'(n), 16'(cnt));
        check(16'(n < 60 && n > 2), 16'h0001);
        // short desaturation inside blanking is ignored
        bus_wr(`GDFN_REG_ENABLE, 16'h001F);
        ctrl.put(1'h0, 1'h1);
        wait_gate(1'h0, 1'h1, n);
        @(posedge clk);
        low_sense.desat <= 1'h1;
        repeat (3) @(posedge clk);
        low_sense.desat <= 1'h0;
        repeat (20) @(posedge clk);
        #1 check(16'({low_gate_drive, side_fault_out_n_oe}), 16'h0002);
        // desaturation after blanking: soft off, latched fault
        @(posedge clk);
        low_sense.desat <= 1'h1;
        n = 0;
        while (low_soft_off !== 1'h1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        check(16'(n < 20), 16'h0001);
        @(posedge clk);
        low_sense.desat <= 1'h0;
        #1 check(16'({low_gate_drive, side_fault_out_n_oe}), 16'h0001);
        cnt = 0;
        flag = 1'h0;
        while (side_fault_out_n_oe === 1'h1 && cnt < 500) begin
            flag = flag | low_gate_drive;
            @(posedge clk);
            #1 cnt++;
        end
        check(16'(cnt >= 20 && cnt < 500), 16'h0001);
        check(16'(flag), 16'h0000);
        repeat (10) @(posedge clk);
        #1 check(16'(low_gate_drive), 16'h0000);
        bus_rd(`GDFN_REG_STATUS, rv);
        check(rv, 16'h0001);
        check(16'(irq), 16'h0001);
        bus_wr(`GDFN_REG_CLEAR, 16'h001F);
        repeat (2) @(posedge clk);
        #1 check(16'(irq), 16'h0000);
        ctrl.put(1'h0, 1'h0);
        ctrl.put(1'h0, 1'h1);
        wait_gate(1'h0, 1'h1, n);
        check(16'(n < 60), 16'h0001);
        ctrl.put(1'h0, 1'h0);
        // undervoltage with no command, interrupt masked then enabled
        bus_wr(`GDFN_REG_ENABLE, 16'h0000);
        high_sense.undervolt <= 1'h1;
        repeat (4) @(posedge clk);
        #1 check(16'(high_soft_off), 16'h0001);
        repeat (4) @(posedge clk);
        #1 check(16'({high_gate_drive, side_fault_out_n_oe, irq}), 16'h0002);
        high_sense.undervolt <= 1'h0;
        bus_rd(`GDFN_REG_STATUS, rv);
        check(rv, 16'h0008);
        bus_wr(`GDFN_REG_ENABLE, 16'h001F);
        repeat (2) @(posedge clk);
        #1 check(16'(irq), 16'h0001);
        bus_wr(`GDFN_REG_CLEAR, 16'h0008);
        cnt = 0;
        while (side_fault_out_n_oe === 1'h1 && cnt < 500) begin
            @(posedge clk);
            #1 cnt++;
        end
        check(16'({irq, side_fault_out_n_oe}), 16'h0000);
        // primary fault while low side conducts
        ctrl.put(1'h0, 1'h1);
        wait_gate(1'h0, 1'h1, n);
        primary_fault <= 1'h1;
        repeat (6) @(posedge clk);
        #1 check(16'({low_gate_drive, high_gate_drive, side_fault_out_n_oe}), 16'h0001);
        // live levels: primary, both side faults shown, direct strap
        bus_rd(`GDFN_REG_LIVE, rv);
        check(rv, 16'h0013);
        primary_fault <= 1'h0;
        ctrl.put(1'h0, 1'h0);
        // local mode from the strap, shorter non-overlap
        do_reset(1'h1);
        bus_wr(`GDFN_REG_NOV, 16'h000A);
        bus_rd(`GDFN_REG_NOV, rv);
        check(rv, 16'h000A);
        ctrl.put(1'h1, 1'h0);
        wait_gate(1'h1, 1'h1, n);
        check(16'({low_gate_drive, high_gate_drive}), 16'h0001);
        ctrl.put(1'h0, 1'h0);
        wait_gate(1'h1, 1'h0, n);
        wait_gate(1'h0, 1'h1, n);
        check(16'(n >= 3 && n < 60), 16'h0001);
        check(16'({low_gate_drive, high_gate_drive}), 16'h0002);
        ctrl.put(1'h1, 1'h0);
        wait_gate(1'h1, 1'h1, n);
        bridge_hold_off_n <= 1'h0;
        repeat (40) @(posedge clk);
        #1 check(16'({low_gate_drive, high_gate_drive}), 16'h0002);
        test_done();
    end
endmodule
`default_nettype wire
